// ===== rtl/isx_exec_unit.v
// Execution unit for one slice of the instruction set
// Functional notes
// [RL1] Swap full contents of any register pair
// [RL2] Sign widen byte-word, word-long, byte-long
// [RL3] Float arithmetic writes destination float register
// [RL4] Compare and probe update only condition byte
// [RL5] Float branch adds displacement when condition true
// [RL6] Decrement-branch: skip if true, stop at -1
// [RL7] Float set writes ones or zeros
// [RL8] Float exception traps when condition true
// [RL9] State store only in supervisor, else trap
// [RL10] State load only in supervisor, else trap
// [RL11] Invalid opcode pushes offset, counter, status
// [RL12] Call pushes return counter, then jumps
// [RL13] Absolute jump loads counter, stack untouched
// [RL14] Frame allocate pushes, links, adds displacement
// [RL15] Multi-move transfers float or control lists
// [RL16] Privilege trap leaves registers unmodified
`timescale 1ns/1ns
`include "isx_regs.vh"
module isx_exec_unit #(
	parameter W = 32
) (
	// Clock and reset
	input  wire          ref_clk,
	input  wire          resetn,
	// Instruction issue
	input  wire          op_valid,
	input  wire [4:0]    op_code,
	input  wire [3:0]    reg_x,
	input  wire [3:0]    reg_y,
	input  wire [2:0]    freg_x,
	input  wire [2:0]    freg_y,
	input  wire [5:0]    cond_sel,
	input  wire [W-1:0]  disp,
	input  wire [W-1:0]  ea_addr,
	input  wire [W-1:0]  next_pc,
	input  wire [W-1:0]  vector_addr,
	input  wire [15:0]   vector_offset,
	input  wire [15:0]   status_word,
	input  wire          supervisor,
	input  wire          multi_dir,
	input  wire          multi_ctrl,
	input  wire          multi_dyn,
	input  wire [7:0]    multi_list,
	// Memory side
	input  wire [W-1:0]  mem_rdata,
	output reg           mem_we,
	output reg  [W-1:0]  mem_addr,
	output reg  [W-1:0]  mem_wdata,
	output reg  [1:0]    mem_size,
	// Architectural state
	output reg  [W-1:0]  program_counter,
	output reg  [W-1:0]  stack_pointer,
	output reg  [W-1:0]  supervisor_stack_pointer,
	output reg  [3:0]    float_condition_byte,
	output reg  [W-1:0]  set_value,
	output reg           trap_pulse,
	output reg  [1:0]    trap_kind,
	output reg           busy
);
	// Register files: 0..7 data, 8..15 address (stack pointers are separate registers)
	reg [W-1:0] gpr_reg [0:15];
	reg [W-1:0] fpr_reg [0:7];
	reg [W-1:0] fctl_reg [0:2];
	reg [W-1:0] fstate_reg;
	reg [2:0]   step_reg;
	reg [7:0]   list_reg;
	reg [4:0]   cur_op_reg;
	integer     i;

	wire [W-1:0] rx = gpr_reg[reg_x];
	wire [W-1:0] ry = gpr_reg[reg_y];
	wire [W-1:0] fresult;
	wire [3:0]   fcc_next;
	wire         cond_true;

	isx_fpu_core #(.W(W)) isx_fpu_core_i (
		.op_code   (op_code),
		.fsrc      (fpr_reg[freg_y]),
		.fdst      (fpr_reg[freg_x]),
		.cond_sel  (cond_sel),
		.fcc_in    (float_condition_byte),
		.fresult   (fresult),
		.fcc_out   (fcc_next),
		.cond_true (cond_true)
	);

	function [2:0] first_set;
		input [7:0] l;
		integer     k;
		begin
			first_set = 3'h0;
			for (k = 7; k >= 0; k = k - 1)
				if (l[k])
					first_set = k[2:0];
		end
	endfunction

	wire [15:0] dec_low = rx[15:0] - 16'h0001;
	wire [7:0]  eff_list = multi_dyn ? rx[7:0] : multi_list;
	wire [W-1:0] sp_cur = supervisor ? supervisor_stack_pointer : stack_pointer;

	// ====================================================================
	// Sequencer
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < 16; i = i + 1)
				gpr_reg[i] <= {W{1'b0}};
			for (i = 0; i < 8; i = i + 1)
				fpr_reg[i] <= {W{1'b0}};
			for (i = 0; i < 3; i = i + 1)
				fctl_reg[i] <= {W{1'b0}};
			fstate_reg <= {W{1'b0}};
			step_reg <= 3'h0;
			list_reg <= 8'h00;
			cur_op_reg <= `ISX_OP_NONE;
			mem_we <= 1'b0;
			mem_addr <= {W{1'b0}};
			mem_wdata <= {W{1'b0}};
			mem_size <= 2'h0;
			program_counter <= `ISX_RST_PC;
			stack_pointer <= `ISX_RST_SP;
			supervisor_stack_pointer <= `ISX_RST_SSP;
			float_condition_byte <= 4'h0;
			set_value <= {W{1'b0}};
			trap_pulse <= 1'b0;
			trap_kind <= `ISX_TRAP_NONE;
			busy <= 1'b0;
		end else begin
			mem_we <= 1'b0;
			trap_pulse <= 1'b0;
			if (busy) begin
				case (cur_op_reg)
					`ISX_OP_INVALID: begin
						case (step_reg)
							3'h1: begin
								mem_we <= 1'b1; // [RL11]
								mem_addr <= supervisor_stack_pointer - `ISX_STEP_LONG;
								mem_wdata <= program_counter;
								mem_size <= 2'h2;
								supervisor_stack_pointer <= supervisor_stack_pointer
									- `ISX_STEP_LONG;
								step_reg <= 3'h2;
							end
							default: begin
								mem_we <= 1'b1; // [RL11]
								mem_addr <= supervisor_stack_pointer - `ISX_STEP_WORD;
								mem_wdata <= {{(W-16){1'b0}}, status_word};
								mem_size <= 2'h1;
								supervisor_stack_pointer <= supervisor_stack_pointer
									- `ISX_STEP_WORD;
								program_counter <= vector_addr;
								trap_pulse <= 1'b1;
								trap_kind <= `ISX_TRAP_INVALID;
								busy <= 1'b0;
							end
						endcase
					end
					`ISX_OP_FMULTI: begin
						if (list_reg == 8'h00) begin
							busy <= 1'b0;
							program_counter <= next_pc;
						end else begin
							// One register per cycle, lowest index first
							mem_size <= 2'h2;
							mem_addr <= mem_addr + `ISX_STEP_LONG;
							list_reg[first_set(list_reg)] <= 1'b0;
							if (multi_dir) begin
								mem_we <= 1'b1; // [RL15]
								mem_wdata <= multi_ctrl ?
									fctl_reg[first_set(list_reg) % 3] :
									fpr_reg[first_set(list_reg)];
							end else if (multi_ctrl) begin
								fctl_reg[first_set(list_reg) % 3] <= mem_rdata; // [RL15]
							end else begin
								fpr_reg[first_set(list_reg)] <= mem_rdata; // [RL15]
							end
						end
					end
					default: busy <= 1'b0;
				endcase
			end else if (op_valid) begin
				program_counter <= next_pc;
				case (op_code)
					`ISX_OP_SWAP: begin
						gpr_reg[reg_x] <= ry; // [RL1]
						gpr_reg[reg_y] <= rx; // [RL1]
					end
					`ISX_OP_WIDEN_BW:
						gpr_reg[reg_x] <= {rx[W-1:16], {8{rx[7]}}, rx[7:0]}; // [RL2]
					`ISX_OP_WIDEN_WL:
						gpr_reg[reg_x] <= {{(W-16){rx[15]}}, rx[15:0]}; // [RL2]
					`ISX_OP_WIDEN_BL:
						gpr_reg[reg_x] <= {{(W-8){rx[7]}}, rx[7:0]}; // [RL2]
					`ISX_OP_FABS, `ISX_OP_FADD, `ISX_OP_FSUB, `ISX_OP_FMUL,
					`ISX_OP_FDIV, `ISX_OP_FNEG, `ISX_OP_FSQRT:
						fpr_reg[freg_x] <= fresult; // [RL3]
					`ISX_OP_FLOAT_COMPARE, `ISX_OP_FPROBE:
						float_condition_byte <= fcc_next; // [RL4]
					`ISX_OP_FBRANCH:
						if (cond_true)
							program_counter <= program_counter + disp; // [RL5]
					`ISX_OP_FDECBR:
						if (!cond_true) begin
							gpr_reg[reg_x] <= {rx[W-1:16], dec_low}; // [RL6]
							if (dec_low != 16'hffff)
								program_counter <= program_counter + disp; // [RL6]
						end
					`ISX_OP_FSET:
						set_value <= cond_true ? {W{1'b1}} : {W{1'b0}}; // [RL7]
					`ISX_OP_FEXCEPT:
						if (cond_true) begin
							trap_pulse <= 1'b1; // [RL8]
							trap_kind <= `ISX_TRAP_COND;
						end
					`ISX_OP_FSTORE, `ISX_OP_FLOAD: begin
						if (!supervisor) begin
							program_counter <= program_counter; // [RL16]
							trap_pulse <= 1'b1; // [RL9] [RL10]
							trap_kind <= `ISX_TRAP_PRIV;
						end else if (op_code == `ISX_OP_FSTORE) begin
							mem_we <= 1'b1; // [RL9]
							mem_addr <= ea_addr;
							mem_wdata <= fstate_reg;
							mem_size <= 2'h2;
						end else begin
							fstate_reg <= mem_rdata; // [RL10]
						end
					end
					`ISX_OP_INVALID: begin
						mem_we <= 1'b1; // [RL11]
						mem_addr <= supervisor_stack_pointer - `ISX_STEP_WORD;
						mem_wdata <= {{(W-16){1'b0}}, vector_offset};
						mem_size <= 2'h1;
						supervisor_stack_pointer <= supervisor_stack_pointer - `ISX_STEP_WORD;
						program_counter <= program_counter;
						cur_op_reg <= op_code;
						step_reg <= 3'h1;
						busy <= 1'b1;
					end
					`ISX_OP_CALL: begin
						mem_we <= 1'b1; // [RL12]
						mem_addr <= sp_cur - `ISX_STEP_LONG;
						mem_wdata <= next_pc;
						mem_size <= 2'h2;
						if (supervisor)
							supervisor_stack_pointer <= sp_cur - `ISX_STEP_LONG;
						else
							stack_pointer <= sp_cur - `ISX_STEP_LONG;
						program_counter <= ea_addr; // [RL12]
					end
					`ISX_OP_JUMP:
						program_counter <= ea_addr; // [RL13]
					`ISX_OP_FRAME: begin
						mem_we <= 1'b1; // [RL14]
						mem_addr <= sp_cur - `ISX_STEP_LONG;
						mem_wdata <= rx;
						mem_size <= 2'h2;
						gpr_reg[reg_x] <= sp_cur - `ISX_STEP_LONG; // [RL14]
						if (supervisor)
							supervisor_stack_pointer <= sp_cur - `ISX_STEP_LONG + disp;
						else
							stack_pointer <= sp_cur - `ISX_STEP_LONG + disp;
					end
					`ISX_OP_FMULTI: begin
						list_reg <= eff_list; // [RL15]
						mem_addr <= ea_addr - `ISX_STEP_LONG;
						cur_op_reg <= op_code;
						program_counter <= program_counter;
						busy <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end
endmodule // isx_exec_unit

// ===== rtl/isx_fpu_core.v
// Floating arithmetic and condition evaluation for the execution unit
`timescale 1ns/1ns
`include "isx_regs.vh"
module isx_fpu_core #(
	parameter W = 32
) (
	// Operation and operands
	input  wire [4:0]   op_code,
	input  wire [W-1:0] fsrc,
	input  wire [W-1:0] fdst,
	input  wire [5:0]   cond_sel,
	input  wire [3:0]   fcc_in,
	// Results
	output reg  [W-1:0] fresult,
	output reg  [3:0]   fcc_out,
	output reg          cond_true
);
	// Operands are treated as signed fixed numbers standing in for reals
	function [3:0] fcc_of;
		input [W-1:0] v;
		begin
			fcc_of = 4'h0;
			fcc_of[`ISX_FCC_N] = v[W-1];
			fcc_of[`ISX_FCC_Z] = (v == {W{1'b0}});
		end
	endfunction

	function [W-1:0] isqrt;
		input [W-1:0] v;
		reg   [W-1:0] r;
		integer       i;
		begin
			r = {W{1'b0}};
			for (i = W/2-1; i >= 0; i = i - 1) begin
				if ((r | ({{(W-1){1'b0}}, 1'b1} << i)) * (r | ({{(W-1){1'b0}}, 1'b1} << i))
					<= v)
					r = r | ({{(W-1){1'b0}}, 1'b1} << i);
			end
			isqrt = r;
		end
	endfunction

	reg [W-1:0] diff;
	reg         n, z, u;

	always @* begin
		diff = fdst - fsrc;
		fresult = fdst;
		fcc_out = fcc_in;
		case (op_code)
			`ISX_OP_FABS:  fresult = fsrc[W-1] ? -fsrc : fsrc; // [RL3]
			`ISX_OP_FADD:  fresult = fdst + fsrc;              // [RL3]
			`ISX_OP_FSUB:  fresult = diff;                     // [RL3]
			`ISX_OP_FMUL:  fresult = fdst * fsrc;              // [RL3]
			`ISX_OP_FDIV: begin
				if (fsrc == {W{1'b0}})
					fresult = {W{1'b1}};
				else
					fresult = $signed(fdst) / $signed(fsrc);   // [RL3]
			end
			`ISX_OP_FNEG:  fresult = -fsrc;                    // [RL3]
			`ISX_OP_FSQRT: fresult = isqrt(fsrc[W-1] ? {W{1'b0}} : fsrc); // [RL3]
			`ISX_OP_FLOAT_COMPARE:  fcc_out = fcc_of(diff);             // [RL4]
			`ISX_OP_FPROBE: fcc_out = fcc_of(fsrc);            // [RL4]
			default: fresult = fdst;
		endcase
		n = fcc_in[`ISX_FCC_N];
		z = fcc_in[`ISX_FCC_Z];
		u = fcc_in[`ISX_FCC_NAN];
		// Low four bits of the predicate pick the test; 0 false, 15 true
		case (cond_sel[3:0])
			4'h0: cond_true = 1'b0;
			4'h1: cond_true = z;
			4'h2: cond_true = ~(u | z | n);
			4'h3: cond_true = z | ~(u | n);
			4'h4: cond_true = n & ~(u | z);
			4'h5: cond_true = z | (n & ~u);
			4'h6: cond_true = ~(u | z);
			4'h7: cond_true = ~u;
			4'h8: cond_true = u;
			4'h9: cond_true = u | z;
			4'ha: cond_true = u | ~(n | z);
			4'hb: cond_true = u | z | ~n;
			4'hc: cond_true = u | (n & ~z);
			4'hd: cond_true = u | z | n;
			4'he: cond_true = ~z;
			default: cond_true = 1'b1;
		endcase
	end
endmodule // isx_fpu_core

// ===== rtl/isx_regs.vh
// Constants for the instruction subset execution unit
`ifndef ISX_REGS_VH
`define ISX_REGS_VH
// Operation codes on op_code
`define ISX_OP_NONE      5'h00
`define ISX_OP_SWAP      5'h01
`define ISX_OP_WIDEN_BW  5'h02
`define ISX_OP_WIDEN_WL  5'h03
`define ISX_OP_WIDEN_BL  5'h04
`define ISX_OP_FABS      5'h05
`define ISX_OP_FADD      5'h06
`define ISX_OP_FSUB      5'h07
`define ISX_OP_FMUL      5'h08
`define ISX_OP_FDIV      5'h09
`define ISX_OP_FNEG      5'h0a
`define ISX_OP_FSQRT     5'h0b
`define ISX_OP_FLOAT_COMPARE      5'h0c
`define ISX_OP_FPROBE    5'h0d
`define ISX_OP_FBRANCH   5'h0e
`define ISX_OP_FDECBR    5'h0f
`define ISX_OP_FSET      5'h10
`define ISX_OP_FEXCEPT   5'h11
`define ISX_OP_FSTORE    5'h12
`define ISX_OP_FLOAD     5'h13
`define ISX_OP_INVALID   5'h14
`define ISX_OP_CALL      5'h15
`define ISX_OP_JUMP      5'h16
`define ISX_OP_FRAME     5'h17
`define ISX_OP_FMULTI    5'h18
// Stack step sizes in bytes
`define ISX_STEP_WORD    32'h0000_0002
`define ISX_STEP_LONG    32'h0000_0004
// Floating condition byte field positions: N Z I NAN
`define ISX_FCC_N        3
`define ISX_FCC_Z        2
`define ISX_FCC_I        1
`define ISX_FCC_NAN      0
// Reset values
`define ISX_RST_PC       32'h0000_0000
`define ISX_RST_SP       32'h0000_0000
`define ISX_RST_SSP      32'h0000_0000
// Trap kinds
`define ISX_TRAP_NONE    2'h0
`define ISX_TRAP_COND    2'h1
`define ISX_TRAP_PRIV    2'h2
`define ISX_TRAP_INVALID 2'h3
`endif

// ===== tb/isx_exec_unit_properties.sv
// Checker for the instruction subset execution unit
`timescale 1ns/1ns
`include "isx_regs.vh"
module isx_exec_unit_properties #(
	parameter W = 32
) (
	// Clock, reset and issue
	input wire         ref_clk,
	input wire         resetn,
	input wire         op_valid,
	input wire [4:0]   op_code,
	input wire [2:0]   freg_x,
	input wire [2:0]   freg_y,
	input wire [5:0]   cond_sel,
	input wire [W-1:0] disp,
	input wire [W-1:0] ea_addr,
	input wire [W-1:0] next_pc,
	input wire [W-1:0] vector_addr,
	input wire [15:0]  vector_offset,
	input wire         supervisor,
	// Results
	input wire         mem_we,
	input wire [W-1:0] mem_addr,
	input wire [W-1:0] mem_wdata,
	input wire [W-1:0] program_counter,
	input wire [W-1:0] stack_pointer,
	input wire [W-1:0] supervisor_stack_pointer,
	input wire [3:0]   float_condition_byte,
	input wire [W-1:0] set_value,
	input wire         trap_pulse,
	input wire [1:0]   trap_kind,
	input wire         busy
);
	wire go = op_valid && !busy;
	wire [3:0] cc = cond_sel[3:0];
	wire pc_eq = next_pc == program_counter;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	AST_CALL: assert property (
		go && op_code == `ISX_OP_CALL && !supervisor |=> mem_we
		&& mem_addr == $past(stack_pointer) - 4 && mem_wdata == $past(next_pc)
		&& stack_pointer == $past(stack_pointer) - 4 && program_counter == $past(ea_addr))
		else $error("call push wrong");
	AST_JUMP: assert property (
		go && op_code == `ISX_OP_JUMP |=> program_counter == $past(ea_addr)
		&& $stable(stack_pointer) && !mem_we)
		else $error("jump wrong");
	AST_INVALID: assert property (
		go && op_code == `ISX_OP_INVALID |=> mem_we
		&& mem_wdata[15:0] == $past(vector_offset)
		&& supervisor_stack_pointer == $past(supervisor_stack_pointer) - 2
		##1 mem_we && supervisor_stack_pointer == $past(supervisor_stack_pointer) - 4
		##1 mem_we && trap_pulse && trap_kind == 2'h3
		&& program_counter == $past(vector_addr, 3))
		else $error("invalid opcode sequence wrong");
	AST_PRIV: assert property (
		go && !supervisor && (op_code == `ISX_OP_FSTORE || op_code == `ISX_OP_FLOAD)
		|=> trap_pulse && trap_kind == 2'h2 && !mem_we && $stable(program_counter)
		&& $stable(stack_pointer) && $stable(supervisor_stack_pointer))
		else $error("privileged trap wrong");
	AST_SET: assert property (
		go && op_code == `ISX_OP_FSET && (cc == 4'hf || cc == 4'h0)
		|=> set_value == {W{$past(cc) == 4'hf}})
		else $error("set value wrong");
	AST_EXCEPT: assert property (
		go && op_code == `ISX_OP_FEXCEPT && (cc == 4'hf || cc == 4'h0)
		|=> trap_pulse == ($past(cc) == 4'hf) && (!trap_pulse || trap_kind == 2'h1))
		else $error("conditional trap wrong");
	AST_BRANCH: assert property (
		go && op_code == `ISX_OP_FBRANCH && pc_eq && cc == 4'hf
		|=> program_counter == $past(program_counter) + $past(disp))
		else $error("branch not taken");
	AST_COMPARE: assert property (
		go && op_code == `ISX_OP_FLOAT_COMPARE && freg_x == freg_y |=> float_condition_byte == 4'h4)
		else $error("compare flags wrong");
	AST_DECBR_TRUE: assert property (
		go && op_code == `ISX_OP_FDECBR && pc_eq && cc == 4'hf |=> $stable(program_counter))
		else $error("decrement branch acted on true");
	C_CALL: cover property (go && op_code == `ISX_OP_CALL);
	C_INV: cover property (go && op_code == `ISX_OP_INVALID);
	C_PRIV: cover property (trap_pulse && trap_kind == 2'h2);
endmodule // isx_exec_unit_properties
bind isx_exec_unit isx_exec_unit_properties #(.W(W)) isx_exec_unit_properties_i (.*);

// ===== tb/isx_exec_unit_test.sv
// Self-checking bench for the instruction subset execution unit
`timescale 1ns/1ns
`include "isx_regs.vh"
module isx_exec_unit_test;
	logic        ref_clk, resetn, op_valid, supervisor, multi_dir, multi_ctrl, multi_dyn;
	logic        mem_we, trap_pulse, busy;
	logic [4:0]  op_code;
	logic [3:0]  reg_x, reg_y, float_condition_byte;
	logic [2:0]  freg_x, freg_y;
	logic [5:0]  cond_sel;
	logic [7:0]  multi_list;
	logic [15:0] vector_offset, status_word;
	logic [1:0]  mem_size, trap_kind;
	logic [31:0] disp, ea_addr, next_pc, vector_addr, mem_rdata, mem_addr, mem_wdata;
	logic [31:0] program_counter, stack_pointer, supervisor_stack_pointer, set_value;
	logic [31:0] s, v, g, lf;
	logic [31:0] wa[$], wd[$];
	logic [1:0]  tk[$];
	int          error_cnt, total_checks, i, k;
	bit          t;
	isx_exec_unit isx_exec_unit_i (.*);
	always #2 ref_clk = ~ref_clk;
	// Capture write pulses and trap pulses as they pass
	always @(posedge ref_clk) begin
		if (mem_we === 1'b1) begin
			wa.push_back(mem_addr);
			wd.push_back(mem_wdata);
		end
		if (trap_pulse === 1'b1)
			tk.push_back(trap_kind);
	end
	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction
	function automatic bit taken(input logic [5:0] c);
		return c == 6'hf || c == 6'h1;
	endfunction
	// Sign widening: 0 byte to word, 1 word to long, 2 byte to long
	function automatic logic [31:0] widen(input int m, input logic [31:0] x);
		return m == 0 ? {x[31:16], {8{x[7]}}, x[7:0]} :
			m == 1 ? {{16{x[15]}}, x[15:0]} : {{24{x[7]}}, x[7:0]};
	endfunction
	function automatic logic [31:0] root(input logic [31:0] x);
		return $rtoi($sqrt(real'(x)));
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (e !== g) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic run(input logic [4:0] op, input logic [5:0] cs);
		int n;
		wa.delete();
		wd.delete();
		tk.delete();
		op_code = op;
		cond_sel = cs;
		op_valid = 1;
		@(negedge ref_clk);
		op_valid = 0;
		n = 0;
		repeat (3) @(negedge ref_clk);
		while (busy !== 1'b0 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		chk("busy_done", 0, busy);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		{ref_clk, resetn, op_valid, supervisor, multi_dir, multi_ctrl, multi_dyn} = 0;
		{op_code, reg_x, reg_y, freg_x, freg_y, cond_sel, multi_list} = 0;
		{disp, ea_addr, next_pc, vector_addr, vector_offset, status_word, mem_rdata} = 0;
		lf = 32'h0000_005d;
		repeat (5) @(negedge ref_clk);
		resetn = 1;
		for (i = 0; i < 4; i++) begin
			ea_addr = rnd();
			s = stack_pointer;
			run(`ISX_OP_JUMP, 0);
			chk("jump_pc", ea_addr, program_counter);
			chk("jump_sp", s, stack_pointer);
			chk("jump_wr", 0, wa.size());
			ea_addr = rnd();
			next_pc = rnd();
			run(`ISX_OP_CALL, 0);
			chk("call_sp", s - 4, stack_pointer);
			chk("call_addr", s - 4, wa[0]);
			chk("call_data", next_pc, wd[0]);
			chk("call_pc", ea_addr, program_counter);
		end
		disp = rnd();
		reg_x = 4'h9;
		s = stack_pointer;
		run(`ISX_OP_FRAME, 0);
		chk("frame_addr", s - 4, wa[0]);
		chk("frame_sp", s - 4 + disp, stack_pointer);
		chk("frame_data", 0, wd[0]);
		// Register 9 now holds the pushed slot address s - 4; frames read registers out
		v = s - 4;
		reg_x = 4'h2;
		run(`ISX_OP_FRAME, 0);
		for (k = 0; k < 3; k++) begin
			g = stack_pointer - disp;
			run(5'(`ISX_OP_WIDEN_BW + k), 0);
			run(`ISX_OP_FRAME, 0);
			chk("widen", widen(k, g), wd[0]);
		end
		g = stack_pointer - disp;
		reg_y = 4'h9;
		run(`ISX_OP_SWAP, 0);
		run(`ISX_OP_FRAME, 0);
		chk("swap_x", v, wd[0]);
		reg_x = 4'h9;
		run(`ISX_OP_FRAME, 0);
		chk("swap_y", g, wd[0]);
		$display("stack tests done");
		vector_addr = rnd();
		vector_offset = 16'(rnd());
		status_word = 16'(rnd());
		next_pc = program_counter;
		s = supervisor_stack_pointer;
		run(`ISX_OP_INVALID, 0);
		chk("inv_a0", s - 2, wa[0]);
		chk("inv_a1", s - 6, wa[1]);
		chk("inv_a2", s - 8, wa[2]);
		chk("inv_off", vector_offset, wd[0][15:0]);
		chk("inv_pc", next_pc, wd[1]);
		chk("inv_sr", status_word, wd[2][15:0]);
		chk("inv_ssp", s - 8, supervisor_stack_pointer);
		chk("inv_vec", vector_addr, program_counter);
		chk("inv_kind", 3, tk[0]);
		$display("invalid opcode test done");
		v = rnd() >> 1;
		mem_rdata = v;
		multi_list = 8'hfe;
		run(`ISX_OP_FMULTI, 0);
		{freg_x, freg_y} = {3'h1, 3'h2};
		run(`ISX_OP_FADD, 0);
		{freg_x, freg_y} = {3'h2, 3'h3};
		run(`ISX_OP_FSUB, 0);
		{freg_x, freg_y} = {3'h3, 3'h4};
		run(`ISX_OP_FNEG, 0);
		{freg_x, freg_y} = {3'h0, 3'h3};
		run(`ISX_OP_FABS, 0);
		run(`ISX_OP_FPROBE, 0);
		chk("probe_fcc", 4'h8, float_condition_byte);
		{freg_x, freg_y} = {3'h6, 3'h5};
		run(`ISX_OP_FDIV, 0);
		{freg_x, freg_y} = {3'h7, 3'h1};
		run(`ISX_OP_FMUL, 0);
		{freg_x, freg_y} = {3'h4, 3'h5};
		run(`ISX_OP_FSQRT, 0);
		{freg_x, freg_y} = {3'h5, 3'h5};
		run(`ISX_OP_FLOAT_COMPARE, 0);
		chk("cmp_fcc", 4'h4, float_condition_byte);
		multi_dir = 1;
		multi_list = 8'h2e;
		ea_addr = rnd() & 32'hffff_fff0;
		run(`ISX_OP_FMULTI, 0);
		chk("multi_cnt", 4, wa.size());
		for (k = 0; k < 4; k++)
			chk("multi_addr", ea_addr + 4 * k, wa[k]);
		chk("add_res", v + v, wd[0]);
		chk("sub_res", 0, wd[1]);
		chk("neg_res", -v, wd[2]);
		chk("cmp_keep", v, wd[3]);
		multi_list = 8'hd1;
		run(`ISX_OP_FMULTI, 0);
		chk("abs_res", v, wd[0]);
		chk("sqrt_res", root(v), wd[1]);
		chk("div_res", 1, wd[2]);
		chk("mul_res", v * (v + v), wd[3]);
		$display("float data tests done");
		for (k = 0; k < 4; k++) begin
			cond_sel = (k == 0) ? 6'h0 : (k == 1) ? 6'hf : (k == 2) ? 6'h1 : 6'he;
			t = taken(cond_sel);
			disp = rnd() & 32'h0000_fffe;
			next_pc = program_counter;
			s = program_counter;
			run(`ISX_OP_FBRANCH, cond_sel);
			chk("br_pc", t ? s + disp : s, program_counter);
			run(`ISX_OP_FSET, cond_sel);
			chk("set_val", {32{t}}, set_value);
			run(`ISX_OP_FEXCEPT, cond_sel);
			chk("exc_cnt", t, tk.size());
		end
		next_pc = program_counter;
		s = program_counter;
		reg_x = 4'h0;
		run(`ISX_OP_FDECBR, 6'hf);
		chk("dec_true", s, program_counter);
		run(`ISX_OP_FDECBR, 6'h0);
		chk("dec_stop", s, program_counter);
		run(`ISX_OP_FDECBR, 6'h0);
		chk("dec_branch", s + disp, program_counter);
		// Register 0 now ends in fe: a seven-entry control list from it
		{multi_dir, multi_ctrl, multi_dyn} = 3'b011;
		mem_rdata = rnd();
		run(`ISX_OP_FMULTI, 0);
		multi_dir = 1;
		run(`ISX_OP_FMULTI, 0);
		chk("ctrl_cnt", 7, wa.size());
		chk("ctrl_data", mem_rdata, wd[6]);
		$display("condition tests done");
		for (k = 0; k < 4; k++) begin
			supervisor = k[1];
			op_code = k[0] ? `ISX_OP_FSTORE : `ISX_OP_FLOAD;
			s = program_counter;
			next_pc = s + 4;
			v = stack_pointer;
			run(op_code, 0);
			chk("priv_trap", !supervisor, tk.size());
			chk("priv_kind", supervisor ? 2'h0 : 2'h2, tk.size() ? tk[0] : 2'h0);
			chk("priv_wr", supervisor && k[0], wa.size());
			if (supervisor && k[0])
				chk("state_rt", mem_rdata, wd[0]);
			chk("priv_pc", supervisor ? s + 4 : s, program_counter);
			chk("priv_sp", v, stack_pointer);
		end
		$display("privilege tests done");
		close_out();
	end
	initial begin
		#20000;
		error_cnt++;
		$display("watchdog expired");
		close_out();
	end
endmodule // isx_exec_unit_test
